//--- hdl/e3dl_regs.vh
// register map, field positions and constants of the e3 data link frame receiver
//
// Overview of operation
// - receiver ignores link bits until software sets control bit 2
// - once on, link bits are searched for the flag octet 0x7E
// - a recognised flag sets status bit 0
// - status bit 0 clears when a non-flag octet is received
// - seven or more ones after a flag is an abort; sets status bit 6
// - back-to-back flags are idle fill and start no frame
// - first non-abort octet after flags starts a frame; bits reassembled into octets
// - payload of a completed frame is stored into the receive buffer
// - a zero following five consecutive ones is deleted before storing
// - crc-16 over header and payload is checked against the two-octet check field
// - status bit 2 set on check mismatch, cleared on match
// - payload is stored whether or not the check passed
// - command/response bit of the address octet is copied to status bit 3
// - command/response 0 means customer installation, 1 means network terminal
// - status bits 5:4 give the message kind from the first payload octet
// - frame done sets control bit 0 and raises the interrupt when enabled
// - frame done also sets the message-complete status bit 1
`ifndef E3DL_REGS_VH
`define E3DL_REGS_VH

`define E3DL_CTRL_ADDR     9'h018
`define E3DL_STAT_ADDR     9'h019
`define E3DL_BUF_BASE      9'h0DE
`define E3DL_BUF_LAST      9'h135
`define E3DL_BUF_DEPTH     88

`define E3DL_CTRL_IRQ_FLAG 0
`define E3DL_CTRL_IRQ_MASK 1
`define E3DL_CTRL_ON       2

`define E3DL_ST_FLAG       0
`define E3DL_ST_EOM        1
`define E3DL_ST_FCS        2
`define E3DL_ST_CR         3
`define E3DL_ST_KIND_LO    4
`define E3DL_ST_KIND_HI    5
`define E3DL_ST_ABORT      6

`define E3DL_CR_BIT        1

`define E3DL_FLAG_OCTET    8'h7E
`define E3DL_STUFF_RUN     3'h5
`define E3DL_ABORT_RUN     3'h6
`define E3DL_ONES_MAX      3'h7

`define E3DL_CRC_INIT      16'hFFFF
`define E3DL_CRC_POLY      16'h8408
`define E3DL_CRC_RESIDUE   16'hF0B8

`define E3DL_HDR_OCTETS    8'h03
`define E3DL_MIN_OCTETS    8'h05
`define E3DL_OCT_MAX       8'hFF

`define E3DL_CODE_TEST     8'h32
`define E3DL_CODE_IDLE     8'h34
`define E3DL_CODE_CLPATH   8'h38
`define E3DL_CODE_ITUPATH  8'h3F
`define E3DL_KIND_TEST     2'h0
`define E3DL_KIND_IDLE     2'h1
`define E3DL_KIND_CLPATH   2'h2
`define E3DL_KIND_ITUPATH  2'h3

`define E3DL_FIFO_DEPTH    32
`define E3DL_FIFO_AW       5

`endif

//--- hdl/e3dl_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module e3dl_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             sys_clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wptr_r;
  reg [AW:0]      rptr_r;

  wire empty = (wptr_r == rptr_r);
  wire full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  wire push  = in_valid && !full;
  wire pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;

  always @* begin
    out_data = mem[rptr_r[AW-1:0]];
  end

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_r <= {(AW+1){1'b0}};
      rptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

endmodule

//--- hdl/e3dl_rx.v
// e3 data link frame receiver: flag hunt, destuffing, crc check, buffer and status
`timescale 1ns/1ps
`include "e3dl_regs.vh"
module e3dl_rx #(
  parameter BUF_DEPTH  = `E3DL_BUF_DEPTH,
  parameter FIFO_DEPTH = `E3DL_FIFO_DEPTH,
  parameter FIFO_AW    = `E3DL_FIFO_AW
) (
  input  wire       sys_clk,
  input  wire       arst_n,
  input  wire       dl_bit,
  input  wire       dl_bit_valid,
  input  wire       up_cs,
  input  wire       up_rd,
  input  wire       up_wr,
  input  wire [8:0] up_addr,
  input  wire [7:0] up_wdata,
  output reg  [7:0] up_rdata,
  output wire       frame_irq,
  output reg        octet_drop
);

  //////////////////////////////////////////////////////////////////////////////
  // receive states

  localparam ST_HUNT = 3'b001;
  localparam ST_IDLE = 3'b010;
  localparam ST_DATA = 3'b100;

  //////////////////////////////////////////////////////////////////////////////
  // crc-16, reflected form, one octet lsb first

  function [15:0] crc_oct;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ d[i]) begin
          t = (t >> 1) ^ `E3DL_CRC_POLY;
        end else begin
          t = t >> 1;
        end
      end
      crc_oct = t;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg        link_receiver_on_r;
  reg        frame_received_irq_mask_r;
  reg        frame_received_irq_flag_r;
  reg        flag_seen_r;
  reg        message_complete_r;
  reg        check_sequence_mismatch_r;
  reg        command_response_value_r;
  reg [1:0]  message_kind_r;
  reg        abort_seen_r;

  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [7:0]  raw_r;
  reg [2:0]  ones_r;
  reg [2:0]  bitcnt_r;
  reg [7:0]  oct_r;
  reg [7:0]  octcnt_r;
  reg [15:0] crc_r;
  reg [7:0]  hold1_r;
  reg [7:0]  hold2_r;
  reg        cr_pend_r;
  reg [1:0]  kind_pend_r;
  reg        fcs_bad_pend_r;
  reg        end_pend_r;

  reg [7:0]  path_maintenance_message [0:BUF_DEPTH-1];
  reg [6:0]  buf_wptr_r;

  //////////////////////////////////////////////////////////////////////////////
  // bit classification

  wire       live     = dl_bit_valid && link_receiver_on_r;
  wire [7:0] raw_nxt  = {dl_bit, raw_r[7:1]};
  wire       flag_det = live && (raw_nxt == `E3DL_FLAG_OCTET);
  wire       abort_det = live && dl_bit && (ones_r == `E3DL_ABORT_RUN);
  wire       stuff_bit = !dl_bit && (ones_r == `E3DL_STUFF_RUN);
  wire       data_bit = live && !flag_det && !abort_det && !stuff_bit &&
                        (ones_r < `E3DL_ABORT_RUN) && (state_r != ST_HUNT);
  wire [7:0] oct_new  = {dl_bit, oct_r[7:1]};
  wire       oct_done = data_bit && (bitcnt_r == 3'h7);
  wire [2:0] ones_nxt = !dl_bit ? 3'h0 :
                        (ones_r == `E3DL_ONES_MAX) ? ones_r : ones_r + 3'h1;

  //////////////////////////////////////////////////////////////////////////////
  // frame state: hunt for a flag, idle between flags, collect frame octets

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HUNT: begin
        if (flag_det) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (flag_det) begin
          state_nxt = ST_IDLE;
        end else if (abort_det) begin
          state_nxt = ST_HUNT;
        end else if (oct_done) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (flag_det) begin
          state_nxt = ST_IDLE;
        end else if (abort_det) begin
          state_nxt = ST_HUNT;
        end
      end
      default: begin
        state_nxt = ST_HUNT;
      end
    endcase
    // a disabled receiver drops back to the hunt
    if (!link_receiver_on_r) begin
      state_nxt = ST_HUNT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // payload fifo: {first of frame, octet}

  wire [8:0] fifo_in;
  wire       fifo_push;
  wire       fifo_in_ready;
  wire [8:0] fifo_out;
  wire       fifo_out_valid;
  wire       fifo_out_ready;

  wire       push_want = oct_done && (state_r == ST_DATA) &&
                         (octcnt_r >= `E3DL_MIN_OCTETS);
  assign fifo_push = push_want && fifo_in_ready;
  assign fifo_in   = {(octcnt_r == `E3DL_MIN_OCTETS), hold2_r};

  e3dl_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_data   (fifo_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // processor access decode

  wire       ctrl_sel = up_cs && (up_addr == `E3DL_CTRL_ADDR);
  wire       stat_sel = up_cs && (up_addr == `E3DL_STAT_ADDR);
  wire       buf_sel  = up_cs && (up_addr >= `E3DL_BUF_BASE) &&
                        (up_addr <= `E3DL_BUF_LAST);
  wire [8:0] buf_off  = up_addr - `E3DL_BUF_BASE;
  wire       ctrl_rd  = ctrl_sel && up_rd;
  wire       ctrl_wr  = ctrl_sel && up_wr;

  // a processor buffer read takes the ram port, so the drain waits
  assign fifo_out_ready = !(buf_sel && up_rd);

  wire       frame_done = end_pend_r && !fifo_out_valid;

  assign frame_irq = frame_received_irq_flag_r && frame_received_irq_mask_r;

  //////////////////////////////////////////////////////////////////////////////
  // control register

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_receiver_on_r        <= 1'b0;
      frame_received_irq_mask_r <= 1'b0;
      frame_received_irq_flag_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        link_receiver_on_r        <= up_wdata[`E3DL_CTRL_ON];
        frame_received_irq_mask_r <= up_wdata[`E3DL_CTRL_IRQ_MASK];
      end
      // setting wins over the clear-on-read
      if (frame_done) begin
        frame_received_irq_flag_r <= 1'b1;
      end else if (ctrl_rd) begin
        frame_received_irq_flag_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit and octet engine

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r        <= ST_HUNT;
      raw_r          <= 8'h00;
      ones_r         <= 3'h0;
      bitcnt_r       <= 3'h0;
      oct_r          <= 8'h00;
      octcnt_r       <= 8'h00;
      crc_r          <= `E3DL_CRC_INIT;
      hold1_r        <= 8'h00;
      hold2_r        <= 8'h00;
      cr_pend_r      <= 1'b0;
      kind_pend_r    <= `E3DL_KIND_TEST;
      fcs_bad_pend_r <= 1'b0;
      end_pend_r     <= 1'b0;
      octet_drop     <= 1'b0;
    end else begin
      octet_drop <= push_want && !fifo_in_ready;
      state_r    <= state_nxt;
      if (frame_done) begin
        end_pend_r <= 1'b0;
      end
      if (!link_receiver_on_r) begin
        raw_r    <= 8'h00;
        ones_r   <= 3'h0;
        bitcnt_r <= 3'h0;
      end else if (dl_bit_valid) begin
        raw_r  <= raw_nxt;
        ones_r <= ones_nxt;
        if (flag_det) begin
          bitcnt_r <= 3'h0;
          if ((state_r == ST_DATA) && (octcnt_r >= `E3DL_MIN_OCTETS)) begin
            end_pend_r     <= 1'b1;
            fcs_bad_pend_r <= (crc_r != `E3DL_CRC_RESIDUE);
          end
        end else if (abort_det) begin
          bitcnt_r <= 3'h0;
        end else if (data_bit) begin
          oct_r    <= oct_new;
          bitcnt_r <= bitcnt_r + 3'h1;
          if (oct_done) begin
            hold1_r <= oct_new;
            hold2_r <= hold1_r;
            if (state_r == ST_IDLE) begin
              octcnt_r  <= 8'h01;
              crc_r     <= crc_oct(`E3DL_CRC_INIT, oct_new);
              cr_pend_r <= oct_new[`E3DL_CR_BIT];
            end else begin
              crc_r <= crc_oct(crc_r, oct_new);
              if (octcnt_r != `E3DL_OCT_MAX) begin
                octcnt_r <= octcnt_r + 8'h01;
              end
              if (octcnt_r == `E3DL_HDR_OCTETS) begin
                case (oct_new)
                  `E3DL_CODE_IDLE:    kind_pend_r <= `E3DL_KIND_IDLE;
                  `E3DL_CODE_CLPATH:  kind_pend_r <= `E3DL_KIND_CLPATH;
                  `E3DL_CODE_ITUPATH: kind_pend_r <= `E3DL_KIND_ITUPATH;
                  default:            kind_pend_r <= `E3DL_KIND_TEST;
                endcase
              end
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status register

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_seen_r               <= 1'b0;
      message_complete_r        <= 1'b0;
      check_sequence_mismatch_r <= 1'b0;
      command_response_value_r  <= 1'b0;
      message_kind_r            <= `E3DL_KIND_TEST;
      abort_seen_r              <= 1'b0;
    end else begin
      if (flag_det) begin
        flag_seen_r <= 1'b1;
      end else if (abort_det || oct_done) begin
        flag_seen_r <= 1'b0;
      end
      if (abort_det && (state_r != ST_HUNT)) begin
        abort_seen_r <= 1'b1;
      end else if (oct_done && (state_r == ST_IDLE)) begin
        abort_seen_r <= 1'b0;
      end
      if (frame_done) begin
        message_complete_r        <= 1'b1;
        check_sequence_mismatch_r <= fcs_bad_pend_r;
        command_response_value_r  <= cr_pend_r;
        message_kind_r            <= kind_pend_r;
      end else if (oct_done && (state_r == ST_IDLE)) begin
        message_complete_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive buffer fill from the fifo

  wire drain = fifo_out_valid && fifo_out_ready;

  always @(posedge sys_clk) begin
    if (drain) begin
      if (fifo_out[8]) begin
        path_maintenance_message[0] <= fifo_out[7:0];
      end else if (buf_wptr_r < BUF_DEPTH) begin
        path_maintenance_message[buf_wptr_r] <= fifo_out[7:0];
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_wptr_r <= 7'h00;
    end else if (drain) begin
      if (fifo_out[8]) begin
        buf_wptr_r <= 7'h01;
      end else if (buf_wptr_r < BUF_DEPTH) begin
        buf_wptr_r <= buf_wptr_r + 7'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_rdata <= 8'h00;
    end else if (up_cs && up_rd) begin
      if (ctrl_sel) begin
        up_rdata <= {5'h00, link_receiver_on_r, frame_received_irq_mask_r,
                     frame_received_irq_flag_r};
      end else if (stat_sel) begin
        up_rdata <= {1'b0, abort_seen_r, message_kind_r, command_response_value_r,
                     check_sequence_mismatch_r, message_complete_r, flag_seen_r};
      end else if (buf_sel) begin
        up_rdata <= path_maintenance_message[buf_off[6:0]];
      end else begin
        up_rdata <= 8'h00;
      end
    end
  end

endmodule

//--- sim/e3dl_rx_properties.sv
// port-level assertions for the data link frame receiver
`timescale 1ns/1ps
module e3dl_rx_chk #(
  parameter BUF_DEPTH  = 88,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input wire       sys_clk,
  input wire       arst_n,
  input wire       dl_bit,
  input wire       dl_bit_valid,
  input wire       up_cs,
  input wire       up_rd,
  input wire       up_wr,
  input wire [8:0] up_addr,
  input wire [7:0] up_wdata,
  input wire [7:0] up_rdata,
  input wire       frame_irq,
  input wire       octet_drop
);
  wire       rd_ctrl = up_cs && up_rd && (up_addr == 9'h018);
  wire       wr_ctrl = up_cs && up_wr && (up_addr == 9'h018);
  wire       rd_stat = up_cs && up_rd && (up_addr == 9'h019);
  wire       in_buf  = (up_addr >= 9'h0DE) && (up_addr <= 9'h135);
  wire       mapped  = (up_addr == 9'h018) || (up_addr == 9'h019) || in_buf;
  reg  [1:0] wbits_r;
  reg        irq_cause_r;

  // remembers the writable control bits and what may lower the interrupt
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wbits_r     <= 2'h0;
      irq_cause_r <= 1'b0;
    end else begin
      if (wr_ctrl)
        wbits_r <= up_wdata[2:1];
      irq_cause_r <= rd_ctrl || (wr_ctrl && !up_wdata[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_rdata_holds: assert property (!(up_cs && up_rd) |=> $stable(up_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (up_cs && up_rd && !mapped |=> up_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_write_back: assert property (wr_ctrl ##1 rd_ctrl |=>
    up_rdata[7:1] == {5'h00, wbits_r})
    else $error("control bits not written");
  a_ctrl_top_zero: assert property (rd_ctrl |=> up_rdata[7:3] == 5'h00)
    else $error("control top bits set");
  a_stat_top_zero: assert property (rd_stat |=> !up_rdata[7])
    else $error("status bit 7 set");
  a_mask_off_irq: assert property (wr_ctrl && !up_wdata[1] |=> !frame_irq)
    else $error("interrupt while masked");
  a_irq_fall_cause: assert property ($fell(frame_irq) |-> irq_cause_r)
    else $error("interrupt dropped without cause");
  a_drop_single: assert property (octet_drop |=> !octet_drop)
    else $error("drop pulse too long");
endmodule

bind e3dl_rx e3dl_rx_chk #(
  .BUF_DEPTH (BUF_DEPTH),
  .FIFO_DEPTH(FIFO_DEPTH),
  .FIFO_AW   (FIFO_AW)
) e3dl_rx_chk_inst (
  .sys_clk     (sys_clk),
  .arst_n      (arst_n),
  .dl_bit      (dl_bit),
  .dl_bit_valid(dl_bit_valid),
  .up_cs       (up_cs),
  .up_rd       (up_rd),
  .up_wr       (up_wr),
  .up_addr     (up_addr),
  .up_wdata    (up_wdata),
  .up_rdata    (up_rdata),
  .frame_irq   (frame_irq),
  .octet_drop  (octet_drop)
);

//--- sim/e3dl_far_tx.sv
// remote link transmitter: one strobed bit at a time, lsb first, zero stuffing
`timescale 1ns/1ps
module e3dl_far_tx (
  input  wire sys_clk,
  output reg  dl_bit,
  output reg  dl_bit_valid
);
  integer gap;
  integer ones;

  initial begin
    dl_bit = 1'b0;
    dl_bit_valid = 1'b0;
    gap = 0;
    ones = 0;
  end

  // line shows the inverse of the last bit between strobes
  task send_bit(input b);
    begin
      @(posedge sys_clk);
      dl_bit <= b;
      dl_bit_valid <= 1'b1;
      @(posedge sys_clk);
      dl_bit_valid <= 1'b0;
      dl_bit <= ~b;
      repeat (gap) @(posedge sys_clk);
    end
  endtask

  task send_octet(input [7:0] v, input stuff);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        send_bit(v[i]);
        ones = (stuff && v[i]) ? ones + 1 : 0;
        if (ones == 5) begin
          send_bit(1'b0);
          ones = 0;
        end
      end
    end
  endtask
endmodule

//--- sim/e3dl_rx_tb.sv
// self-checking bench of the data link frame receiver
`timescale 1ns/1ps
`include "e3dl_regs.vh"
module e3dl_rx_tb;
  reg         sys_clk  = 1'b0;
  reg         arst_n   = 1'b0;
  reg         up_cs    = 1'b0;
  reg         up_rd    = 1'b0;
  reg         up_wr    = 1'b0;
  reg  [8:0]  up_addr  = 9'h000;
  reg  [7:0]  up_wdata = 8'h00;
  wire [7:0]  up_rdata;
  wire        frame_irq;
  wire        dl_bit;
  wire        dl_bit_valid;
  wire        octet_drop;
  reg         drop_seen = 1'b0;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     k;
  reg  [8:0]  ba;
  reg  [15:0] rnd = 16'h0010;
  reg  [7:0]  st;
  reg  [7:0]  pay [0:5];

  always #12.5 sys_clk = ~sys_clk;

  // a dropped payload octet is remembered until the end of the run
  always @(posedge sys_clk) begin
    if (octet_drop) begin
      drop_seen <= 1'b1;
    end
  end

  e3dl_rx e3dl_rx_inst (.sys_clk(sys_clk), .arst_n(arst_n), .dl_bit(dl_bit),
    .dl_bit_valid(dl_bit_valid), .up_cs(up_cs), .up_rd(up_rd), .up_wr(up_wr),
    .up_addr(up_addr), .up_wdata(up_wdata), .up_rdata(up_rdata),
    .frame_irq(frame_irq), .octet_drop(octet_drop));
  e3dl_far_tx e3dl_far_tx_inst (.sys_clk(sys_clk), .dl_bit(dl_bit), .dl_bit_valid(dl_bit_valid));

  ////////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] crc_step(input [15:0] c, input [7:0] d);
    integer b;
    begin
      crc_step = c ^ {8'h00, d};
      for (b = 0; b < 8; b = b + 1)
        crc_step = crc_step[0] ? (crc_step >> 1) ^ `E3DL_CRC_POLY : crc_step >> 1;
    end
  endfunction
  function [1:0] kind_of(input [7:0] c);
    kind_of = (c == 8'h34) ? 2'h1 : (c == 8'h38) ? 2'h2 : (c == 8'h3F) ? 2'h3 : 2'h0;
  endfunction
  function [7:0] code_of(input integer n);
    code_of = (n == 0) ? 8'h32 : (n == 1) ? 8'h34 : (n == 2) ? 8'h38 : (n == 3) ? 8'h3F : rnd[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task acc(input w, input [8:0] a, input [7:0] d);
    begin
      up_cs <= 1'b1;
      up_wr <= w;
      up_rd <= !w;
      up_addr <= a;
      up_wdata <= d;
      @(posedge sys_clk);
    end
  endtask
  task reg_rd(input [8:0] a, output [7:0] d);
    begin
      acc(1'b0, a, 8'h00);
      up_cs <= 1'b0;
      up_rd <= 1'b0;
      @(negedge sys_clk);
      d = up_rdata;
      @(posedge sys_clk);
    end
  endtask
  task reg_wr(input [8:0] a, input [7:0] d);
    begin
      acc(1'b1, a, d);
      up_cs <= 1'b0;
      up_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task flags(input integer n);
    repeat (n) e3dl_far_tx_inst.send_octet(`E3DL_FLAG_OCTET, 1'b0);
  endtask
  task send_frame(input [7:0] code, input cr, input bad);
    reg [7:0]  f [0:10];
    reg [15:0] c;
    integer    j;
    begin
      f[0] = cr ? 8'h3E : 8'h3C;
      f[1] = 8'h01;
      f[2] = 8'h03;
      pay[0] = code;
      pay[1] = 8'hFF;
      pay[2] = 8'h7E;
      pay[3] = rnd[7:0];
      pay[4] = rnd[15:8];
      rnd = lfsr(rnd);
      pay[5] = rnd[7:0];
      c = `E3DL_CRC_INIT;
      for (j = 0; j < 6; j = j + 1)
        f[j + 3] = pay[j];
      for (j = 0; j < 9; j = j + 1)
        c = crc_step(c, f[j]);
      c = ~c ^ {15'h0000, bad};
      f[9] = c[7:0];
      f[10] = c[15:8];
      flags(2);
      e3dl_far_tx_inst.send_octet(f[0], 1'b1);
      reg_rd(`E3DL_STAT_ADDR, st);
      check(st & 8'h01, 8'h00);
      for (j = 1; j < 11; j = j + 1)
        e3dl_far_tx_inst.send_octet(f[j], 1'b1);
      flags(1);
    end
  endtask
  task wait_done;
    integer n;
    begin
      st = 8'h00;
      for (n = 0; n < 200 && !st[1]; n = n + 1)
        reg_rd(`E3DL_STAT_ADDR, st);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    reg_rd(`E3DL_CTRL_ADDR, st);
    check(st, 8'h00);
    reg_rd(`E3DL_STAT_ADDR, st);
    check(st, 8'h00);
    reg_rd(9'h01A, st);
    check(st, 8'h00);
    reg_wr(`E3DL_STAT_ADDR, 8'hFF);
    reg_rd(`E3DL_STAT_ADDR, st);
    check(st, 8'h00);
    acc(1'b1, `E3DL_CTRL_ADDR, 8'hFF);
    reg_rd(`E3DL_CTRL_ADDR, st);
    check(st, 8'h06);
    reg_wr(`E3DL_CTRL_ADDR, 8'h00);
    send_frame(8'h32, 1'b0, 1'b0);
    reg_rd(`E3DL_STAT_ADDR, st);
    check(st, 8'h00);
    reg_wr(`E3DL_CTRL_ADDR, 8'h06);
    flags(3);
    reg_rd(`E3DL_STAT_ADDR, st);
    check(st, 8'h01);
    e3dl_far_tx_inst.send_octet(8'hFF, 1'b0);
    reg_rd(`E3DL_STAT_ADDR, st);
    check(st, 8'h40);
    for (k = 0; k < 5; k = k + 1) begin
      e3dl_far_tx_inst.gap = rnd[1:0];
      rnd = lfsr(rnd);
      send_frame(code_of(k), k[0], k[1]);
      wait_done;
      check(st & 8'h0B, {4'h0, k[0], 3'h3});
      check(st & 8'hF4, {2'h0, kind_of(pay[0]), 1'b0, k[1], 2'h0});
      check({7'h00, frame_irq}, 8'h01);
      reg_rd(`E3DL_CTRL_ADDR, st);
      check(st, 8'h07);
      reg_rd(`E3DL_CTRL_ADDR, st);
      check(st, 8'h06);
      for (ba = `E3DL_BUF_BASE; ba < `E3DL_BUF_BASE + 9'h006; ba = ba + 9'h001) begin
        reg_rd(ba, st);
        check(st, pay[ba - `E3DL_BUF_BASE]);
      end
    end
    check({7'h00, drop_seen}, 8'h00);
    results;
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures = failures + 1;
    results;
  end
endmodule
